// file: core/mri_reset_init.sv
// Purpose: reset pin handling and state initialisation of a 4-bit controller core
// Assumes: reset pin is asynchronous; registers reached over APB, one word each
// Notes:   working registers and data RAM carry no reset on purpose
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "mri_consts.svh"

module mri_reset_init (
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  input  wire logic                     reset_pin,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic                          in_reset,
  output logic                          fetch_en,
  output logic      [`MRI_PC_W-1:0]     pc,
  output logic                          branch_condition_flag,
  output logic                          interrupt_master_enable,
  output logic      [`MRI_IRQ_W-1:0]    interrupt_request,
  output logic      [`MRI_IRQ_W-1:0]    interrupt_mask_bits,
  output logic      [`MRI_PORT_W-1:0]   port_output_latch,
  output logic      [`MRI_PORT_W-1:0]   port_direction_control,
  output mri_pkg::mri_nib_t             port_select_a,
  output mri_pkg::mri_nib_t             port_select_b,
  output mri_pkg::mri_nib_t             timer_a_config,
  output mri_pkg::mri_nib_t             timer_b_config,
  output mri_pkg::mri_nib_t             timer_c_config,
  output mri_pkg::mri_nib_t             serial_config,
  output logic      [2:0]               display_control,
  output mri_pkg::mri_nib_t             display_duty_clock,
  output logic                          low_speed_flag,
  output logic                          watchdog_flag,
  output logic                          direct_transfer_flag
);
  import mri_pkg::*;

  // ----------------------------------------------------------------
  // reset pin synchroniser and instruction-cycle divider
  // ----------------------------------------------------------------
  logic             rst_meta;
  logic             rst_sync;
  logic [1:0]       div_cnt;
  logic             instr_tick;
  mri_state_t       state;
  mri_state_t       next_state;

  // two flops before any use: the pin is asynchronous to core_clk
  // flops come out of srst as "held", so init has no gap before the pin is seen
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= reset_pin;
      rst_sync <= rst_meta;
    end
  end

  // init covers both the core reset and the synchronised pin
  wire init = srst | rst_sync;

  // free-running instruction enable, also while the reset pin is held; only srst stops it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_cnt    <= 2'd0;
      instr_tick <= 1'b0;
    end else begin
      div_cnt    <= (div_cnt == `MRI_INSTR_DIV) ? 2'd0 : div_cnt + 2'd1;
      instr_tick <= (div_cnt == `MRI_INSTR_DIV);
    end
  end

  // ----------------------------------------------------------------
  // sequencer: hold while reset, start until the next instruction tick (1 to 4 core clocks), run
  // ----------------------------------------------------------------
  // the start state waits for an instruction boundary so fetch lines up
  // with the instruction clock; reset length itself is the source's duty
  assign next_state = init ? MRI_HOLD :
                      (state == MRI_HOLD)                  ? MRI_START :
                      (state == MRI_START && instr_tick)   ? MRI_RUN   : state;

  always_ff @(posedge core_clk) begin
    state    <= next_state;
    in_reset <= init;
    fetch_en <= (next_state == MRI_RUN);
  end

  // fetch address: zero on reset, steps once per instruction while running
  always_ff @(posedge core_clk) begin
    if (init) begin
      pc <= `MRI_PC_RST;
    end else if (fetch_en && instr_tick) begin
      pc <= pc + `MRI_PC_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // one wait state: pready rises on the first access edge
  wire acc_first = psel & penable & ~pready;
  wire acc_done  = psel & penable & pready;
  wire ram_hit   = (paddr[7:6] == `MRI_RAM_BASE_HI);
  wire [3:0] ram_idx = paddr[5:2];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // writes are refused while reset holds, so reset values stay put
  wire wr_ok  = acc_done & pwrite & ~init;
  wire wr_flg = wr_ok & hit(paddr, `MRI_OFS_FLAGS);
  wire wr_lat = wr_ok & hit(paddr, `MRI_OFS_PLATCH);
  wire wr_dir = wr_ok & hit(paddr, `MRI_OFS_PDIR);
  wire wr_psl = wr_ok & hit(paddr, `MRI_OFS_PSEL);
  wire wr_tcf = wr_ok & hit(paddr, `MRI_OFS_TCFG);
  wire wr_tcn = wr_ok & hit(paddr, `MRI_OFS_TCNT);
  wire wr_trl = wr_ok & hit(paddr, `MRI_OFS_TRLD);
  wire wr_dsp = wr_ok & hit(paddr, `MRI_OFS_DISP);
  wire wr_mod = wr_ok & hit(paddr, `MRI_OFS_MODE);
  wire wr_wrk = wr_ok & hit(paddr, `MRI_OFS_WORK);
  wire wr_ram = wr_ok & ram_hit;

  // ----------------------------------------------------------------
  // initialised state
  // ----------------------------------------------------------------
  mri_byte_t        timer_a_count;
  mri_byte_t        timer_b_count;
  mri_byte_t        timer_c_count;
  mri_byte_t        timer_b_reload;
  mri_byte_t        timer_c_reload;
  logic [11:0]      presc_sys;
  mri_byte_t        presc_watch;
  logic [2:0]       octal_count;

  // flags and interrupt control
  always_ff @(posedge core_clk) begin
    if (init) begin
      branch_condition_flag   <= 1'b1;
      interrupt_master_enable <= 1'b0;
      interrupt_request       <= '0;
      interrupt_mask_bits     <= `MRI_MASK_RST;
    end else if (wr_flg) begin
      branch_condition_flag   <= pwdata[0];
      interrupt_master_enable <= pwdata[1];
      interrupt_request       <= pwdata[7:4];
      interrupt_mask_bits     <= pwdata[11:8];
    end
  end

  // ports: latches high, buffers off, select modes cleared
  always_ff @(posedge core_clk) begin
    if (init) begin
      port_output_latch      <= `MRI_LATCH_RST;
      port_direction_control <= `MRI_DIR_RST;
      port_select_a          <= `MRI_NIB_RST;
      port_select_b          <= `MRI_NIB_RST;
    end else begin
      if (wr_lat) port_output_latch      <= pwdata[15:0];
      if (wr_dir) port_direction_control <= pwdata[15:0];
      if (wr_psl) begin
        port_select_a <= pwdata[3:0];
        port_select_b <= pwdata[7:4];
      end
    end
  end

  // timer and serial configuration
  always_ff @(posedge core_clk) begin
    if (init) begin
      timer_a_config <= `MRI_NIB_RST;
      timer_b_config <= `MRI_NIB_RST;
      timer_c_config <= `MRI_NIB_RST;
      serial_config  <= `MRI_NIB_RST;
    end else if (wr_tcf) begin
      timer_a_config <= pwdata[3:0];
      timer_b_config <= pwdata[7:4];
      timer_c_config <= pwdata[11:8];
      serial_config  <= pwdata[15:12];
    end
  end

  // timer counts and reloads, software loaded
  always_ff @(posedge core_clk) begin
    if (init) begin
      timer_a_count  <= `MRI_BYTE_RST;
      timer_b_count  <= `MRI_BYTE_RST;
      timer_c_count  <= `MRI_BYTE_RST;
      timer_b_reload <= `MRI_BYTE_RST;
      timer_c_reload <= `MRI_BYTE_RST;
    end else begin
      if (wr_tcn) begin
        timer_a_count <= pwdata[7:0];
        timer_b_count <= pwdata[15:8];
        timer_c_count <= pwdata[23:16];
      end
      if (wr_trl) begin
        timer_b_reload <= pwdata[7:0];
        timer_c_reload <= pwdata[15:8];
      end
    end
  end

  // prescalers run on instruction ticks; octal counter on watch wrap
  wire watch_wrap = instr_tick & (presc_watch == 8'hff);
  always_ff @(posedge core_clk) begin
    if (init) begin
      presc_sys   <= `MRI_PRS_RST;
      presc_watch <= `MRI_BYTE_RST;
      octal_count <= `MRI_OCT_RST;
    end else if (instr_tick) begin
      presc_sys   <= presc_sys + 12'd1;
      presc_watch <= presc_watch + 8'd1;
      if (watch_wrap) octal_count <= octal_count + 3'd1;
    end
  end

  // display and mode flags
  always_ff @(posedge core_clk) begin
    if (init) begin
      display_control      <= `MRI_DISP_RST;
      display_duty_clock   <= `MRI_NIB_RST;
      low_speed_flag       <= 1'b0;
      watchdog_flag        <= 1'b0;
      direct_transfer_flag <= 1'b0;
    end else begin
      if (wr_dsp) begin
        display_control    <= pwdata[2:0];
        display_duty_clock <= pwdata[7:4];
      end
      if (wr_mod) begin
        low_speed_flag       <= pwdata[0];
        watchdog_flag        <= pwdata[1];
        direct_transfer_flag <= pwdata[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // uninitialised storage
  // ----------------------------------------------------------------
  logic             add_overflow_flag;
  mri_nib_t         accum;
  mri_byte_t        serial_shift_word;
  mri_nib_t         ram [`MRI_RAM_WORDS];

  // no reset term: software must load these after every reset
  always_ff @(posedge core_clk) begin
    if (wr_wrk) begin
      add_overflow_flag <= pwdata[0];
      accum             <= pwdata[7:4];
      serial_shift_word <= pwdata[15:8];
    end
  end

  // RAM keeps its words; writes are already blocked while in reset
  always_ff @(posedge core_clk) begin
    if (wr_ram) ram[ram_idx] <= pwdata[3:0];
  end

  // ----------------------------------------------------------------
  // read mux and APB answer
  // ----------------------------------------------------------------
  wire [31:0] rd_status = {29'h0, branch_condition_flag, fetch_en, in_reset};
  wire [31:0] rd_flags  = {20'h0, interrupt_mask_bits, interrupt_request,
                           2'b00, interrupt_master_enable, branch_condition_flag};
  wire [31:0] rd_tcfg   = {16'h0, serial_config, timer_c_config,
                           timer_b_config, timer_a_config};
  wire [31:0] rd_presc  = {9'h0, octal_count, presc_watch, presc_sys};
  wire [31:0] rd_work   = {16'h0, serial_shift_word, accum, 3'b000, add_overflow_flag};
  wire        mapped    = ram_hit | (paddr[7:6] == 2'b00 && paddr <= `MRI_OFS_WORK
                                     && paddr[1:0] == 2'b00);
  wire [31:0] rd_word =
    ram_hit                          ? {28'h0, ram[ram_idx]} :
    hit(paddr, `MRI_OFS_STATUS)      ? rd_status :
    hit(paddr, `MRI_OFS_FLAGS)       ? rd_flags :
    hit(paddr, `MRI_OFS_PLATCH)      ? {16'h0, port_output_latch} :
    hit(paddr, `MRI_OFS_PDIR)        ? {16'h0, port_direction_control} :
    hit(paddr, `MRI_OFS_PSEL)        ? {24'h0, port_select_b, port_select_a} :
    hit(paddr, `MRI_OFS_TCFG)        ? rd_tcfg :
    hit(paddr, `MRI_OFS_TCNT)        ? {8'h0, timer_c_count, timer_b_count, timer_a_count} :
    hit(paddr, `MRI_OFS_TRLD)        ? {16'h0, timer_c_reload, timer_b_reload} :
    hit(paddr, `MRI_OFS_PRESC)       ? rd_presc :
    hit(paddr, `MRI_OFS_DISP)        ? {24'h0, display_duty_clock, 1'b0, display_control} :
    hit(paddr, `MRI_OFS_MODE)        ? {29'h0, direct_transfer_flag, watchdog_flag,
                                        low_speed_flag} :
    hit(paddr, `MRI_OFS_WORK)        ? rd_work : 32'h0;

  // answer registered one cycle into the access phase
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~mapped;
      if (acc_first) prdata <= pwrite ? 32'h0 : rd_word;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  pin_enters_a: assert property (rst_sync |=> in_reset && !fetch_en)
    else $error("reset pin did not enter reset");
  pc_top_a: assert property (in_reset |-> pc == `MRI_PC_RST)
    else $error("pc not at start address in reset");
  branch_set_a: assert property (in_reset |-> branch_condition_flag)
    else $error("branch flag not set by reset");
  irq_block_a: assert property (in_reset |-> !interrupt_master_enable
    && interrupt_request == '0 && interrupt_mask_bits == `MRI_MASK_RST)
    else $error("interrupt state not blocked by reset");
  port_init_a: assert property (in_reset |-> port_output_latch == `MRI_LATCH_RST
    && port_direction_control == `MRI_DIR_RST)
    else $error("port latches or direction wrong in reset");
  port_sel_a: assert property (in_reset |-> port_select_a == 4'h0
    && port_select_b == 4'h0)
    else $error("port select not cleared");
  cfg_clear_a: assert property (in_reset |-> timer_a_config == 4'h0
    && timer_b_config == 4'h0 && timer_c_config == 4'h0 && serial_config == 4'h0)
    else $error("timer or serial config not cleared");
  count_clear_a: assert property (in_reset |-> presc_sys == 12'h0
    && presc_watch == 8'h0 && octal_count == 3'h0 && timer_a_count == 8'h0
    && timer_b_count == 8'h0 && timer_c_count == 8'h0
    && timer_b_reload == 8'h0 && timer_c_reload == 8'h0)
    else $error("counters not cleared");
  disp_clear_a: assert property (in_reset |-> display_control == 3'h0
    && display_duty_clock == 4'h0)
    else $error("display registers not cleared");
  mode_clear_a: assert property (in_reset |-> !low_speed_flag
    && !watchdog_flag && !direct_transfer_flag)
    else $error("mode flags not cleared");
  ram_keep_a: assert property (in_reset && $past(in_reset)
    |-> ram[0] === $past(ram[0]))
    else $error("ram word changed during reset");
  fetch_late_a: assert property ($fell(in_reset) |-> !fetch_en && state != MRI_RUN)
    else $error("fetch began too soon after release");
  fetch_start_a: assert property ($fell(in_reset) |-> ##[1:6] fetch_en)
    else $error("fetch did not start after release");

  reset_pulse_c: cover property ($rose(in_reset) ##[2:20] $fell(in_reset));
  run_write_c:   cover property (fetch_en && wr_flg);
  ram_write_c:   cover property (wr_ram ##[1:40] in_reset);
  unmapped_c:    cover property (pslverr && pready);
endmodule

// file: core/mri_consts.svh
// Purpose: offsets, widths, reset values and counts of the reset initialiser
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   included by core/mri_reset_init.sv only
`ifndef MRI_CONSTS_SVH
`define MRI_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MRI_OFS_STATUS   8'h00
`define MRI_OFS_FLAGS    8'h04
`define MRI_OFS_PLATCH   8'h08
`define MRI_OFS_PDIR     8'h0c
`define MRI_OFS_PSEL     8'h10
`define MRI_OFS_TCFG     8'h14
`define MRI_OFS_TCNT     8'h18
`define MRI_OFS_TRLD     8'h1c
`define MRI_OFS_PRESC    8'h20
`define MRI_OFS_DISP     8'h24
`define MRI_OFS_MODE     8'h28
`define MRI_OFS_WORK     8'h2c
`define MRI_RAM_BASE_HI  2'b01

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define MRI_PC_W         14
`define MRI_PORT_W       16
`define MRI_IRQ_W        4
`define MRI_RAM_WORDS    16
`define MRI_PC_RST       14'h0000
`define MRI_LATCH_RST    16'hffff
`define MRI_DIR_RST      16'h0000
`define MRI_MASK_RST     4'hf
`define MRI_NIB_RST      4'h0
`define MRI_BYTE_RST     8'h00
`define MRI_PRS_RST      12'h000
`define MRI_OCT_RST      3'h0
`define MRI_DISP_RST     3'h0

// ----------------------------------------------------------------
// timing: last divider count; four core clocks per instruction cycle
// ----------------------------------------------------------------
`define MRI_INSTR_DIV    2'd3
`endif

// file: core/mri_pkg.sv
// Purpose: shared types of the reset initialiser
// Assumes: constants live in mri_consts.svh
// Notes:   state codes follow a Gray path hold -> start -> run
package mri_pkg;
  typedef logic [3:0] mri_nib_t;
  typedef logic [7:0] mri_byte_t;
  typedef enum logic [1:0] {
    MRI_HOLD  = 2'b00,
    MRI_START = 2'b01,
    MRI_RUN   = 2'b11
  } mri_state_t;
endpackage

// file: bench/mri_reset_source.sv
// Purpose: model of the reset source that sits outside the controller core
// Assumes: start is a one-cycle request; settle picks the long oscillator hold
// Notes:   the pin is held high from power-on for the settle span
`timescale 1ns/10ps
module mri_reset_source #(
  parameter int SHORT_HOLD  = 8,
  parameter int SETTLE_HOLD = 64
) (
  input  wire logic core_clk,
  input  wire logic start,
  input  wire logic settle,
  output logic      reset_pin
);
  int left;

  // power-on: the source holds the pin through the oscillator settle span
  initial begin
    reset_pin = 1'b1;
    left      = SETTLE_HOLD;
  end

  // never shorter than two instruction cycles, long hold after stop exit
  always @(posedge core_clk) begin
    if (start && left == 0) begin
      reset_pin <= 1'b1;
      left      <= settle ? SETTLE_HOLD : SHORT_HOLD;
    end else if (left > 1) begin
      left <= left - 1;
    end else if (left == 1) begin
      left      <= 0;
      reset_pin <= 1'b0;
    end
  end
endmodule

// file: bench/tb_mri_reset_init.sv
// Purpose: self-checking bench of the reset initialiser
// Assumes: the reset source model drives the pin; apb answers after one wait state
// Notes:   the driver queues each apb result, a watcher compares on completion
`timescale 1ns/10ps
module tb_mri_reset_init;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        core_clk, srst, psel, penable, pwrite, start, settle, reset_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d, ram_v;
  logic        pready, pslverr, in_reset, fetch_en, branch_condition_flag;
  logic        interrupt_master_enable, low_speed_flag, watchdog_flag;
  logic        direct_transfer_flag;
  logic [13:0] pc;
  logic [15:0] port_output_latch, port_direction_control;
  logic [3:0]  interrupt_request, interrupt_mask_bits, port_select_a, port_select_b;
  logic [3:0]  timer_a_config, timer_b_config, timer_c_config, serial_config;
  logic [3:0]  display_duty_clock;
  logic [2:0]  display_control;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          seed = 17803, miscompares = 0, check_count = 0, n, i;
  // register table: address, writable mask, reset value
  logic [7:0]  ra[9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24, 8'h28};
  logic [31:0] rm[9] = '{'hff3, 'hffff, 'hffff, 'hff, 'hffff, 'hffffff, 'hffff, 'hf7, 'h7};
  logic [31:0] rv[9] = '{'hf01, 'hffff, 0, 0, 0, 0, 0, 0, 0};

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  mri_reset_source #(.SETTLE_HOLD(120)) mri_reset_source_inst (.core_clk, .start, .settle,
    .reset_pin);

  mri_reset_init mri_reset_init_inst (.core_clk, .srst, .reset_pin, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .in_reset, .fetch_en, .pc,
    .branch_condition_flag, .interrupt_master_enable, .interrupt_request,
    .interrupt_mask_bits, .port_output_latch, .port_direction_control, .port_select_a,
    .port_select_b, .timer_a_config, .timer_b_config, .timer_c_config, .serial_config,
    .display_control, .display_duty_clock, .low_speed_flag, .watchdog_flag,
    .direct_transfer_flag);

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watcher: oldest note against each completed transfer
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33]) chk(prdata, e[31:0]);
    end
  end

  // master holds the request until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic err,
           input logic [31:0] ed);
    exp_q.push_back({wr, err, ed});
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next call never re-drives psel in this step
    @(posedge core_clk);
  endtask

  // bounded wait on in_reset (sel 1) or fetch_en (sel 0)
  task wait_sig(input logic sel, input logic lvl, input int lim);
    n = 0;
    while ((sel ? in_reset : fetch_en) !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, n >= lim}, 0);
  endtask

  task port_reset_check;
    chk(pc, 0);
    chk(branch_condition_flag, 1);
    chk({interrupt_master_enable, interrupt_request, interrupt_mask_bits}, 'h00f);
    chk(port_output_latch, 'hffff);
    chk(port_direction_control, 0);
    chk({port_select_a, port_select_b}, 0);
    chk({timer_a_config, timer_b_config, timer_c_config, serial_config}, 0);
    chk(display_control, 0);
    chk(display_duty_clock, 0);
    chk({low_speed_flag, watchdog_flag, direct_transfer_flag}, 0);
    chk({fetch_en, in_reset}, 'h1);
  endtask

  task pulse_pin(input logic long_hold);
    settle <= long_hold;
    start  <= 1'b1;
    @(posedge core_clk);
    start  <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, start, settle, paddr, pwdata} = '0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    wait_sig(1'b0, 1'b1, 300);
    apb(0, 8'h00, 0, 0, 'h6);
    // random writes; bit 0 always differs from its reset value
    for (i = 0; i < 9; i++) begin
      d = ($random(seed) | 32'h1) ^ rv[i];
      apb(1, ra[i], d, 0, 0);
      apb(0, ra[i], 0, 0, d & rm[i]);
    end
    ram_v = $random(seed);
    apb(1, 8'h40, ram_v, 0, 0);
    apb(1, 8'h30, ram_v, 1, 0);
    apb(0, 8'h30, 0, 1, 0);
    // long hold, as after stop mode; writes inside it are dropped
    pulse_pin(1'b1);
    wait_sig(1'b1, 1'b1, 8);
    port_reset_check;
    apb(1, 8'h08, 0, 0, 0);
    for (i = 0; i < 9; i++) apb(0, ra[i], 0, 0, rv[i]);
    apb(0, 8'h20, 0, 0, 0);
    apb(0, 8'h00, 0, 0, 'h5);
    apb(0, 8'h40, 0, 0, ram_v & 'hf);
    port_reset_check;
    wait_sig(1'b1, 1'b0, 300);
    chk(fetch_en, 0);
    wait_sig(1'b0, 1'b1, 6);
    // dirty every register first, so the short pulse has something to undo
    for (i = 0; i < 9; i++) apb(1, ra[i], ~rv[i], 0, 0);
    // shortest legal pulse: two instruction cycles
    pulse_pin(1'b0);
    wait_sig(1'b1, 1'b1, 8);
    port_reset_check;
    wait_sig(1'b1, 1'b0, 20);
    wait_sig(1'b0, 1'b1, 6);
    for (i = 0; i < 9; i++) apb(0, ra[i], 0, 0, rv[i]);
    repeat (8) @(posedge core_clk);
    chk({31'h0, pc != 0}, 1);
    close_out;
  end

  // hang guard, well past the expected run of some 450 cycles
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
endmodule
